/* File: hw/pmsdr_top.sv */
//------------------------------------------------------------------------------
// Purpose: converter status pair, fault flags, alert, scratch and delay bank
// Assumes: command port driven by a PMBus engine, inputs synchronous to CLK
// Notes:   NRST models the supply being cycled
//------------------------------------------------------------------------------
`timescale 1ns/1ns

module pmsdr_top
    import pmsdr_pkg::*;
#(
    parameter int DLY_BASE_CYCLES = GOOD_DLY_BASE_CYC,
    parameter int DLY_EXTRA_CYCLES = ON_DLY_EXTRA_CYC
) (
    input wire logic CLK,
    input wire logic NRST,
    // command port from the PMBus engine
    input wire logic CMD_STB,
    input wire logic [7:0] CMD_CODE,
    input wire logic WR_STB,
    input wire logic [7:0] WR_BYTE,
    input wire logic RD_STB,
    output logic [7:0] RD_BYTE,
    output logic RD_VALID,
    // analog side
    input wire pmsdr_fault_t FAULTS,
    input wire logic ENABLE_REQ,
    input wire logic OUTPUT_ACTIVE,
    input wire logic SOFT_START_DONE,
    output logic START_EN,
    output logic POWER_GOOD_LOW_OUT,
    // open-drain alert, enable high while pulling low
    output logic ALERT_O,
    output logic ALERT_OE
);

    //--------------------------------------------------------------------------
    // functions
    //--------------------------------------------------------------------------

    // power-good delay in cycles, load value is count minus one
    function automatic logic [CNT_W-1:0] good_dly_load(input logic [2:0] code);
        int cyc;
        cyc = (code == GOOD_DLY_LONG_CODE) ? (DLY_BASE_CYCLES << GOOD_DLY_LONG_SHIFT)
                                           : (DLY_BASE_CYCLES << code);
        return CNT_W'(cyc - 1);
    endfunction

    // power-on delay: fixed offset plus the doubling ladder
    function automatic logic [CNT_W-1:0] on_dly_load(input logic [2:0] code);
        int cyc;
        cyc = DLY_EXTRA_CYCLES + (DLY_BASE_CYCLES << code);
        return CNT_W'(cyc - 1);
    endfunction

    // assemble the 16-bit status pair from flags and live conditions
    function automatic logic [15:0] status_of(input pmsdr_fault_t fl,
                                              input logic sum_v,
                                              input logic sum_i,
                                              input logic sum_in,
                                              input logic off,
                                              input logic pg_low);
        logic [15:0] w;
        w = 16'h0000;
        w[BIT_OFF] = off;
        w[BIT_OV] = fl.out_ov;
        w[BIT_OC] = fl.out_oc;
        w[BIT_UV] = fl.in_uv;
        w[BIT_OT] = fl.over_temp;
        w[BIT_CML] = fl.comm_memory_logic_flag;
        w[BIT_OUTPUT_VOLT_SUMMARY_SUM] = sum_v;
        w[BIT_OUTPUT_CURRENT_SUMMARY_SUM] = sum_i;
        w[BIT_INPUT_SUM] = sum_in;
        w[BIT_PG_LOW] = pg_low;
        return w;
    endfunction

    //--------------------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------------------
    pmsdr_fault_t flags_r;
    logic sum_v_r;
    logic sum_i_r;
    logic sum_in_r;
    logic enable_q_r;
    logic clear_cmd;
    logic clear_en;
    logic clear_any;
    logic cml_evt;
    logic [7:0] code_r;
    logic [1:0] byte_idx_r;
    logic [15:0] snap_r;
    logic [15:0] status_now;
    logic [SCRATCH_W-1:0] scratch_r;
    logic [DELAY_W-1:0] delay_r;
    pmsdr_seq_t seq_r;
    pmsdr_seq_t seq_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [7:0] rd_byte_nxt;

    //--------------------------------------------------------------------------
    // clearing events
    //--------------------------------------------------------------------------

    // send-byte clear, and an off-to-on edge of the configured enable
    assign clear_cmd = CMD_STB && (CMD_CODE == CMD_CLEAR_FAULTS);
    assign clear_en = ENABLE_REQ && !enable_q_r;
    assign clear_any = clear_cmd || clear_en;

    // unknown codes, writes to read-only status and data on clear are faults
    assign cml_evt = (CMD_STB && !(CMD_CODE inside {CMD_CLEAR_FAULTS, CMD_STATUS_LOW,
                      CMD_STATUS_PAIR, CMD_USER_SCRATCH, CMD_DELAY_SELECT}))
                  || (WR_STB && !(code_r inside {CMD_USER_SCRATCH, CMD_DELAY_SELECT}));

    // enable history for edge detection; cleared by supply cycling
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            enable_q_r <= 1'b0;
        end else begin
            enable_q_r <= ENABLE_REQ;
        end
    end

    //--------------------------------------------------------------------------
    // latched fault flags
    //--------------------------------------------------------------------------

    // set beats clear, so a fault still present reappears at once
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            flags_r <= '0;
            sum_v_r <= 1'b0;
            sum_i_r <= 1'b0;
            sum_in_r <= 1'b0;
        end else begin
            flags_r.out_ov <= (flags_r.out_ov && !clear_any) || FAULTS.out_ov;
            flags_r.out_oc <= (flags_r.out_oc && !clear_any) || FAULTS.out_oc;
            flags_r.in_uv <= (flags_r.in_uv && !clear_any) || FAULTS.in_uv;
            flags_r.over_temp <= (flags_r.over_temp && !clear_any) || FAULTS.over_temp;
            flags_r.comm_memory_logic_flag <= (flags_r.comm_memory_logic_flag && !clear_any) || FAULTS.comm_memory_logic_flag || cml_evt;
            // warning inputs only feed the summaries, no flag of their own
            flags_r.out_volt_warn <= 1'b0;
            flags_r.out_curr_warn <= 1'b0;
            flags_r.in_volt_warn <= 1'b0;
            sum_v_r <= (sum_v_r && !clear_any) || FAULTS.out_ov || FAULTS.out_volt_warn;
            sum_i_r <= (sum_i_r && !clear_any) || FAULTS.out_oc || FAULTS.out_curr_warn;
            sum_in_r <= (sum_in_r && !clear_any) || FAULTS.in_uv || FAULTS.in_volt_warn;
        end
    end

    // live view: latched flags plus off and power-good bits taken from present conditions
    assign status_now = status_of(flags_r, sum_v_r, sum_i_r, sum_in_r,
                                  !OUTPUT_ACTIVE, !POWER_GOOD_LOW_OUT);

    //--------------------------------------------------------------------------
    // alert pin
    //--------------------------------------------------------------------------

    // pulled low while any fault is flagged; clearing drops it for one cycle
    // at most, then a lasting condition pulls it again
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ALERT_OE <= 1'b0;
            ALERT_O <= 1'b0;
        end else begin
            ALERT_OE <= (flags_r.out_ov || flags_r.out_oc || flags_r.in_uv
                        || flags_r.over_temp || flags_r.comm_memory_logic_flag
                        || sum_v_r || sum_i_r || sum_in_r) && !clear_any;
            ALERT_O <= 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // command capture and read path
    //--------------------------------------------------------------------------

    // the status is frozen at the command byte so a word read never tears
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            code_r <= 8'h00;
            snap_r <= 16'h0000;
            byte_idx_r <= 2'h0;
        end else if (CMD_STB) begin
            code_r <= CMD_CODE;
            snap_r <= status_now;
            byte_idx_r <= 2'h0;
        end else if (RD_STB && byte_idx_r != 2'h3) begin
            byte_idx_r <= byte_idx_r + 2'h1;
        end
    end

    // byte selection; bytes past the register width read zero
    always_comb begin
        rd_byte_nxt = 8'h00;
        if (byte_idx_r == 2'h0) begin
            case (code_r)
                CMD_STATUS_LOW: rd_byte_nxt = snap_r[7:0];
                CMD_STATUS_PAIR: rd_byte_nxt = snap_r[7:0];
                CMD_USER_SCRATCH: rd_byte_nxt = {2'h0, scratch_r};
                CMD_DELAY_SELECT: rd_byte_nxt = {2'h0, delay_r};
                default: rd_byte_nxt = 8'h00;
            endcase
        end else if (byte_idx_r == 2'h1 && code_r == CMD_STATUS_PAIR) begin
            rd_byte_nxt = snap_r[15:8];
        end
    end

    // one byte per read strobe, answered on the next edge
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RD_BYTE <= 8'h00;
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= RD_STB;
            if (RD_STB) begin
                RD_BYTE <= rd_byte_nxt;
            end
        end
    end

    //--------------------------------------------------------------------------
    // writable registers
    //--------------------------------------------------------------------------

    // scratch keeps only the low six bits; the NVM copy lives elsewhere
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            scratch_r <= SCRATCH_RST;
        end else if (WR_STB && code_r == CMD_USER_SCRATCH) begin
            scratch_r <= WR_BYTE[SCRATCH_W-1:0];
        end
    end

    // delay select drops the two unimplemented top bits
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            delay_r <= DELAY_RST;
        end else if (WR_STB && code_r == CMD_DELAY_SELECT) begin
            delay_r <= WR_BYTE[DELAY_W-1:0];
        end
    end

    //--------------------------------------------------------------------------
    // start-up sequencer
    //--------------------------------------------------------------------------

    // delays are sampled at the start of each wait; a write mid-wait only
    // affects later waits, which avoids a jump in the running count
    always_comb begin
        seq_nxt = seq_r;
        cnt_nxt = cnt_r;
        if (!ENABLE_REQ) begin
            seq_nxt = SEQ_IDLE;
            cnt_nxt = '0;
        end else begin
            case (seq_r)
                SEQ_IDLE: begin
                    seq_nxt = SEQ_ON_WAIT;
                    cnt_nxt = on_dly_load(delay_r[ON_DLY_MSB:ON_DLY_LSB]);
                end
                SEQ_ON_WAIT: begin
                    if (cnt_r == '0) begin
                        seq_nxt = SEQ_SOFT;
                    end else begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                end
                SEQ_SOFT: begin
                    if (SOFT_START_DONE) begin
                        seq_nxt = SEQ_GOOD_WAIT;
                        cnt_nxt = good_dly_load(delay_r[GOOD_DLY_MSB:GOOD_DLY_LSB]);
                    end
                end
                SEQ_GOOD_WAIT: begin
                    if (cnt_r == '0) begin
                        seq_nxt = SEQ_RUN;
                    end else begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                end
                SEQ_RUN: seq_nxt = SEQ_RUN;
                default: begin
                    seq_nxt = SEQ_IDLE;
                    cnt_nxt = '0;
                end
            endcase
        end
    end

    // state and counter
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            seq_r <= SEQ_IDLE;
            cnt_r <= '0;
        end else begin
            seq_r <= seq_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // switching enable after power-on delay, power-good after its delay
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            START_EN <= 1'b0;
            POWER_GOOD_LOW_OUT <= 1'b0;
        end else begin
            START_EN <= seq_nxt inside {SEQ_SOFT, SEQ_GOOD_WAIT, SEQ_RUN};
            POWER_GOOD_LOW_OUT <= (seq_nxt == SEQ_RUN);
        end
    end

endmodule // pmsdr_top

/* File: hw/pmsdr_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: shared constants and types for the status and delay register bank
// Assumes: 250 MHz core clock, command port fed by a PMBus protocol engine
// Notes:   every offset, field position, reset value and cycle count lives here
//------------------------------------------------------------------------------
package pmsdr_pkg;

    //--------------------------------------------------------------------------
    // command codes
    //--------------------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STATUS_LOW = 8'h78;
    localparam logic [7:0] CMD_STATUS_PAIR = 8'h79;
    localparam logic [7:0] CMD_USER_SCRATCH = 8'hD0;
    localparam logic [7:0] CMD_DELAY_SELECT = 8'hD1;

    //--------------------------------------------------------------------------
    // status pair bit positions
    //--------------------------------------------------------------------------
    localparam int BIT_OFF = 6;
    localparam int BIT_OV = 5;
    localparam int BIT_OC = 4;
    localparam int BIT_UV = 3;
    localparam int BIT_OT = 2;
    localparam int BIT_CML = 1;
    localparam int BIT_OUTPUT_VOLT_SUMMARY_SUM = 15;
    localparam int BIT_OUTPUT_CURRENT_SUMMARY_SUM = 14;
    localparam int BIT_INPUT_SUM = 13;
    localparam int BIT_PG_LOW = 11;

    //--------------------------------------------------------------------------
    // field layout and values after reset
    //--------------------------------------------------------------------------
    localparam int SCRATCH_W = 6;
    localparam int DELAY_W = 6;
    localparam int GOOD_DLY_MSB = 5;
    localparam int GOOD_DLY_LSB = 3;
    localparam int ON_DLY_MSB = 2;
    localparam int ON_DLY_LSB = 0;
    localparam logic [5:0] SCRATCH_RST = 6'h00;
    localparam logic [5:0] DELAY_RST = 6'h12;
    localparam logic [2:0] GOOD_DLY_LONG_CODE = 3'h7;
    localparam int GOOD_DLY_LONG_SHIFT = 9;

    //--------------------------------------------------------------------------
    // timing: times in their own unit, cycle counts derived from the clock
    //--------------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int GOOD_DLY_BASE_NS = 256000;
    localparam int ON_DLY_EXTRA_NS = 100000;
    localparam int GOOD_DLY_BASE_CYC = GOOD_DLY_BASE_NS * 1000 / CLK_PERIOD_PS;
    localparam int ON_DLY_EXTRA_CYC = ON_DLY_EXTRA_NS * 1000 / CLK_PERIOD_PS;
    localparam int CNT_W = 26;

    //--------------------------------------------------------------------------
    // types
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic out_ov;
        logic out_oc;
        logic in_uv;
        logic over_temp;
        logic comm_memory_logic_flag;
        logic out_volt_warn;
        logic out_curr_warn;
        logic in_volt_warn;
    } pmsdr_fault_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0,
        SEQ_ON_WAIT = 3'h1,
        SEQ_SOFT = 3'h3,
        SEQ_GOOD_WAIT = 3'h2,
        SEQ_RUN = 3'h6
    } pmsdr_seq_t;

endpackage

/* File: dv/pmsdr_checker.sv */
// Purpose: port-level assertions for the status and delay bank
// Assumes: one clock domain, NRST synchronous and active low
// Notes:   flags are internal, so alert timing stands in for them
`timescale 1ns/1ns
module pmsdr_checker
    import pmsdr_pkg::*;
#(
    parameter int DLY_BASE_CYCLES = GOOD_DLY_BASE_CYC,
    parameter int DLY_EXTRA_CYCLES = ON_DLY_EXTRA_CYC
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CMD_STB,
    input wire logic [7:0] CMD_CODE,
    input wire logic WR_STB,
    input wire logic [7:0] WR_BYTE,
    input wire logic RD_STB,
    input wire logic [7:0] RD_BYTE,
    input wire logic RD_VALID,
    input wire pmsdr_fault_t FAULTS,
    input wire logic ENABLE_REQ,
    input wire logic OUTPUT_ACTIVE,
    input wire logic SOFT_START_DONE,
    input wire logic START_EN,
    input wire logic POWER_GOOD_LOW_OUT,
    input wire logic ALERT_O,
    input wire logic ALERT_OE
);
    logic en_q_r;
    logic [CNT_W-1:0] en_cnt_r;
    wire clr_ev = (CMD_STB && CMD_CODE == CMD_CLEAR_FAULTS) || (ENABLE_REQ && !en_q_r);

    // enable edge history and time spent enabled; saturates so it never wraps
    always_ff @(posedge CLK) begin
        en_q_r <= NRST && ENABLE_REQ;
        if (!NRST || !ENABLE_REQ) begin
            en_cnt_r <= '0;
        end else if (en_cnt_r != '1) begin
            en_cnt_r <= en_cnt_r + 1'b1;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    alert_follow_a: assert property ((|FAULTS && !clr_ev) ##1 !clr_ev ##1 !clr_ev |-> ALERT_OE)
        else $error("alert not raised two cycles after a fault");
    clear_release_a: assert property (clr_ev |=> !ALERT_OE)
        else $error("alert still driven after a clear event");
    alert_refire_a: assert property ((clr_ev && |FAULTS) ##1 (|FAULTS && !clr_ev) |=> ALERT_OE)
        else $error("alert not restored for a lasting fault");
    stay_clear_a: assert property ((clr_ev && FAULTS == '0) ##1 (FAULTS == '0 && !clr_ev) |=> !ALERT_OE)
        else $error("alert returned with no fault");
    rd_answer_a: assert property (RD_STB |=> RD_VALID)
        else $error("read strobe not answered next cycle");
    rd_pulse_a: assert property (RD_VALID |-> $past(RD_STB))
        else $error("read valid without a request");
    seq_drop_a: assert property (!ENABLE_REQ |=> !START_EN && !POWER_GOOD_LOW_OUT)
        else $error("outputs kept after enable dropped");
    start_wait_a: assert property ($rose(START_EN) |-> en_cnt_r > DLY_EXTRA_CYCLES + DLY_BASE_CYCLES)
        else $error("switching allowed before shortest power-on delay");
    power_good_low_order_a: assert property ($rose(POWER_GOOD_LOW_OUT) |-> START_EN && $past(SOFT_START_DONE))
        else $error("power good before soft start finished");
    alert_data_a: assert property (ALERT_O == 1'b0)
        else $error("open-drain alert data not held low");

    cover property (clr_ev && |FAULTS);
    cover property ($rose(POWER_GOOD_LOW_OUT));
    cover property (RD_VALID ##1 RD_VALID);
endmodule // pmsdr_checker

bind pmsdr_top pmsdr_checker #(.DLY_BASE_CYCLES(DLY_BASE_CYCLES), .DLY_EXTRA_CYCLES(DLY_EXTRA_CYCLES)) chk_i (
    .CLK, .NRST, .CMD_STB, .CMD_CODE, .WR_STB, .WR_BYTE, .RD_STB, .RD_BYTE, .RD_VALID, .FAULTS,
    .ENABLE_REQ, .OUTPUT_ACTIVE, .SOFT_START_DONE, .START_EN, .POWER_GOOD_LOW_OUT, .ALERT_O, .ALERT_OE);

/* File: dv/pmsdr_host_model.sv */
// Purpose: PMBus host stand-in driving the command port
// Assumes: strobes launched 1 ns after the rising edge
// Notes:   idle code and data lines show the inverted last value, never a stale copy
`timescale 1ns/1ns
module pmsdr_host_model (
    input wire logic clk,
    input wire logic [7:0] rd_byte,
    input wire logic rd_valid,
    input wire logic alert_oe,
    output logic cmd_stb,
    output logic [7:0] cmd_code,
    output logic wr_stb,
    output logic [7:0] wr_byte,
    output logic rd_stb
);
    initial begin
        cmd_stb = 1'b0;
        cmd_code = 8'h00;
        wr_stb = 1'b0;
        wr_byte = 8'h00;
        rd_stb = 1'b0;
    end

    // command byte opens a transaction; following bytes refer to it
    task automatic send(input logic [7:0] code);
        @(posedge clk);
        #1;
        cmd_stb = 1'b1;
        cmd_code = code;
        @(posedge clk);
        #1;
        cmd_stb = 1'b0;
        cmd_code = ~code;
    endtask

    task automatic put(input logic [7:0] data);
        @(posedge clk);
        #1;
        wr_stb = 1'b1;
        wr_byte = data;
        @(posedge clk);
        #1;
        wr_stb = 1'b0;
        wr_byte = ~data;
    endtask

    // answer is registered, so it is taken right after the sampling edge
    task automatic get(output logic [7:0] data, output logic vld);
        @(posedge clk);
        #1;
        rd_stb = 1'b1;
        @(posedge clk);
        #1;
        rd_stb = 1'b0;
        data = rd_byte;
        vld = rd_valid;
    endtask

    // faults are serviced on the alert line instead of by polling
    task automatic wait_alert(output logic seen);
        seen = 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (alert_oe) seen = 1'b1;
        end
    endtask
endmodule // pmsdr_host_model

/* File: dv/pmbus_status_and_delay_regs_tb.sv */
// Purpose: self-checking bench for the status and delay bank
// Assumes: delay counts shortened through the top parameters
// Notes:   expected status words are built from the bit map, not read back
`timescale 1ns/1ns
module pmbus_status_and_delay_regs_tb;
    import pmsdr_pkg::*;
    localparam int DLY_B = 4;
    localparam int DLY_X = 2;
    localparam logic [15:0] BASE = 16'h0840; // idle: output off, power good low
    localparam logic [15:0] FMAP [8] = '{16'h8020, 16'h4010, 16'h2008, 16'h0004,
                                         16'h0002, 16'h8000, 16'h4000, 16'h2000};
    logic CLK = 1'b0;
    logic NRST, CMD_STB, WR_STB, RD_STB, RD_VALID, ENABLE_REQ, OUTPUT_ACTIVE, SOFT_START_DONE;
    logic START_EN, POWER_GOOD_LOW_OUT, ALERT_O, ALERT_OE, seen;
    logic [7:0] CMD_CODE, WR_BYTE, RD_BYTE;
    logic [15:0] v;
    pmsdr_fault_t FAULTS;
    int mismatches = 0;
    int n_compared = 0;

    always #2 CLK = ~CLK;

    pmsdr_top #(.DLY_BASE_CYCLES(DLY_B), .DLY_EXTRA_CYCLES(DLY_X)) dut (
        .CLK(CLK), .NRST(NRST), .CMD_STB(CMD_STB), .CMD_CODE(CMD_CODE), .WR_STB(WR_STB),
        .WR_BYTE(WR_BYTE), .RD_STB(RD_STB), .RD_BYTE(RD_BYTE), .RD_VALID(RD_VALID), .FAULTS(FAULTS),
        .ENABLE_REQ(ENABLE_REQ), .OUTPUT_ACTIVE(OUTPUT_ACTIVE), .SOFT_START_DONE(SOFT_START_DONE),
        .START_EN(START_EN), .POWER_GOOD_LOW_OUT(POWER_GOOD_LOW_OUT), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE));

    pmsdr_host_model host (
        .clk(CLK), .rd_byte(RD_BYTE), .rd_valid(RD_VALID), .alert_oe(ALERT_OE), .cmd_stb(CMD_STB),
        .cmd_code(CMD_CODE), .wr_stb(WR_STB), .wr_byte(WR_BYTE), .rd_stb(RD_STB));

    //--------------------------------------------------------------------------
    // shared helpers
    //--------------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // two bytes every time: single-byte registers must send zero second
    task automatic rd_reg(input logic [7:0] code, output logic [15:0] val);
        logic v0, v1;
        host.send(code);
        host.get(val[7:0], v0);
        host.get(val[15:8], v1);
        chk("read valid", {14'h0000, v0, v1}, 16'h0003);
    endtask

    task automatic wr_reg(input logic [7:0] code, input logic [7:0] data);
        host.send(code);
        host.put(data);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    //--------------------------------------------------------------------------
    // scenarios
    //--------------------------------------------------------------------------
    task automatic t_defaults();
        rd_reg(CMD_STATUS_PAIR, v);
        chk("pair idle", v, BASE);
        rd_reg(CMD_STATUS_LOW, v);
        chk("low idle", v, {8'h00, BASE[7:0]});
        rd_reg(CMD_USER_SCRATCH, v);
        chk("scratch dflt", v, 16'h0000);
        rd_reg(CMD_DELAY_SELECT, v);
        chk("delay dflt", v, {10'h000, DELAY_RST});
    endtask

    // each fault for one cycle: flag must outlive it until cleared
    task automatic t_flags();
        for (int i = 0; i < 8; i++) begin
            FAULTS = pmsdr_fault_t'(8'h80 >> i);
            @(posedge CLK);
            #1;
            FAULTS = '0;
            host.wait_alert(seen);
            chk("alert", {15'h0000, seen}, 16'h0001);
            rd_reg(CMD_STATUS_PAIR, v);
            chk("flag pair", v, BASE | FMAP[i]);
            rd_reg(CMD_STATUS_LOW, v);
            chk("flag low", v, {8'h00, BASE[7:0] | FMAP[i][7:0]});
            host.send(CMD_CLEAR_FAULTS);
            rd_reg(CMD_STATUS_PAIR, v);
            chk("cleared", v, BASE);
            chk("alert off", {15'h0000, ALERT_OE}, 16'h0000);
        end
    endtask

    task automatic t_persist();
        FAULTS.over_temp = 1'b1;
        repeat (3) @(posedge CLK);
        host.send(CMD_CLEAR_FAULTS);
        repeat (2) @(posedge CLK);
        #1;
        chk("alert back", {15'h0000, ALERT_OE}, 16'h0001);
        chk("alert data", {15'h0000, ALERT_O}, 16'h0000);
        rd_reg(CMD_STATUS_PAIR, v);
        chk("flag back", v, BASE | 16'h0004);
        FAULTS = '0;
        host.send(CMD_CLEAR_FAULTS);
        rd_reg(CMD_STATUS_PAIR, v);
        chk("gone", v, BASE);
    endtask

    // upper bits dropped; unknown code and write to read-only both flag comm
    task automatic t_regs();
        wr_reg(CMD_USER_SCRATCH, 8'hFF);
        rd_reg(CMD_USER_SCRATCH, v);
        chk("scratch", v, 16'h003F);
        wr_reg(CMD_DELAY_SELECT, 8'hC0);
        rd_reg(CMD_DELAY_SELECT, v);
        chk("delay top", v, 16'h0000);
        host.send(8'h55);
        rd_reg(CMD_STATUS_LOW, v);
        chk("bad code", v, 16'h0042);
        host.send(CMD_CLEAR_FAULTS);
        wr_reg(CMD_STATUS_LOW, 8'h01);
        rd_reg(CMD_STATUS_LOW, v);
        chk("ro write", v, 16'h0042);
        host.send(CMD_CLEAR_FAULTS);
    endtask

    // enable rise also clears a latched flag
    task automatic t_seq(input logic [2:0] gd, input logic [2:0] od);
        int k;
        k = 0;
        wr_reg(CMD_DELAY_SELECT, {2'h3, gd, od});
        FAULTS.comm_memory_logic_flag = 1'b1;
        @(posedge CLK);
        #1;
        FAULTS = '0;
        ENABLE_REQ = 1'b1;
        do begin @(posedge CLK); #1; k++; end while (!START_EN && k < 3000);
        chk("on delay", 16'(k), 16'(DLY_X + (DLY_B << od) + 1));
        OUTPUT_ACTIVE = 1'b1;
        SOFT_START_DONE = 1'b1;
        k = 0;
        do begin @(posedge CLK); #1; k++; end while (!POWER_GOOD_LOW_OUT && k < 3000);
        chk("pg delay", 16'(k), 16'(((gd == GOOD_DLY_LONG_CODE) ? (DLY_B << 9) : (DLY_B << gd)) + 1));
        rd_reg(CMD_STATUS_PAIR, v);
        chk("running", v, 16'h0000);
        ENABLE_REQ = 1'b0;
        OUTPUT_ACTIVE = 1'b0;
        SOFT_START_DONE = 1'b0;
        rd_reg(CMD_STATUS_PAIR, v);
        chk("stopped", v, BASE);
    endtask

    task automatic t_power_cycle();
        FAULTS.out_oc = 1'b1;
        wr_reg(CMD_USER_SCRATCH, 8'h2A);
        FAULTS = '0;
        chk("alert pre", {15'h0000, ALERT_OE}, 16'h0001);
        NRST = 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        NRST = 1'b1;
        chk("rd rst", {7'h00, RD_VALID, RD_BYTE}, 16'h0000);
        rd_reg(CMD_STATUS_PAIR, v);
        chk("cycled", v, BASE);
        rd_reg(CMD_USER_SCRATCH, v);
        chk("scratch rst", v, 16'h0000);
        rd_reg(CMD_DELAY_SELECT, v);
        chk("delay rst", v, {10'h000, DELAY_RST});
    endtask

    initial begin
        NRST = 1'b0;
        FAULTS = '0;
        ENABLE_REQ = 1'b0;
        OUTPUT_ACTIVE = 1'b0;
        SOFT_START_DONE = 1'b0;
        repeat (16) @(posedge CLK);
        #1;
        NRST = 1'b1;
        t_defaults();
        t_flags();
        t_persist();
        t_regs();
        t_seq(3'h0, 3'h7);
        t_seq(3'h7, 3'h0);
        t_seq(3'h5, 3'h3);
        t_power_cycle();
        final_report();
    end

    // whole run is a few thousand cycles; this is about eight times that
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule // pmbus_status_and_delay_regs_tb
